/* File: hdl/pwb_consts.svh */
// Purpose: Offsets, field positions, reset values and timing for the pulse-width timer and buzzer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Bit positions index the low byte of the 32-bit word
// Behaviour
// - Mode pair bits 7 and 6 both one selects pulse-width measurement.
// - Counter counts system, system/4, low-frequency or timer clock; system sources prescaled.
// - In pulse-width mode, setting run bit 4 only arms; counting starts at first active pin edge.
// - Edge bit 3 low: start on falling edge, stop and clear run on rise.
// - Edge bit high: start on rising edge, stop and clear run on fall.
// - Run bit self-clears only in pulse-width mode; otherwise only software clears it.
// - After auto stop count is held and pin ignored until run set again.
// - Start and stop follow detected pin transitions, never static levels.
// - Overflow raises request, reloads from preload and keeps counting.
// - Each overflow sets request flag; interrupt output only when enable set.
// - Overflow during power-down with request flag clear gives wake-up regardless of interrupt enable.
// - Pin events take effect at the next system clock after synchronising, not at the next timer clock pulse.
// - Counter read or preload write inhibits the counting clock.
// - Buzzer is timer zero or one overflow divided by two, chosen by source select.
// - With both buzzer pins outputs and first pin data 1, second pin is the exact inverse of the first.
// - Both buzzer pins outputs: first pin data 1 enables, 0 forces both low.
// - Second pin data bit has no effect on the inverted buzzer output.
// - Direction bit high makes a buzzer pin an input; lone second pin then non-inverted.
// - Function register bit 1 second pin, bit 0 first pin; both reset to I/O.
`ifndef PWB_CONSTS_SVH
`define PWB_CONSTS_SVH

`define PWB_OFS_CTRL     8'h00
`define PWB_OFS_PRELOAD  8'h04
`define PWB_OFS_COUNT    8'h08
`define PWB_OFS_STATUS   8'h0c
`define PWB_OFS_CTRL2    8'h10
`define PWB_OFS_PINFN    8'h14
`define PWB_OFS_PORTDIR  8'h18
`define PWB_OFS_PORTDAT  8'h1c

`define PWB_CTRL_MODE_HI 7
`define PWB_CTRL_MODE_LO 6
`define PWB_CTRL_RUN     4
`define PWB_CTRL_EDGE    3
`define PWB_CTRL_PSC_HI  2
`define PWB_CTRL_RST     8'h08
`define PWB_MODE_TIMER   2'b10
`define PWB_MODE_PWIDTH  2'b11

`define PWB_CTRL2_IEN    0
`define PWB_CTRL2_BZSRC  1
`define PWB_CTRL2_CSEL   2
`define PWB_CSEL_SYS     2'b00
`define PWB_CSEL_SYS4    2'b01
`define PWB_CSEL_LF      2'b10
`define PWB_CSEL_TCK     2'b11

`define PWB_PINFN_FIRST  0
`define PWB_PINFN_SECOND 1
`define PWB_PIN_FIRST    1
`define PWB_PIN_SECOND   2
`define PWB_PORTDIR_RST  8'hff

`define PWB_SYS4_DIV     2'b11

`endif

/* File: hdl/pwb_pkg.sv */
// Purpose: Types for the pulse-width timer and buzzer
// Assumes: Constants live in pwb_consts.svh
// Notes: One-hot state codes
package pwb_pkg;
    typedef enum logic [2:0] {
        PWB_IDLE  = 3'b001,
        PWB_ARMED = 3'b010,
        PWB_COUNT = 3'b100
    } pwb_state_t;
endpackage

/* File: hdl/pwb_top.sv */
// Purpose: Pulse-width measuring timer with overflow reload, request flag and buzzer pins
// Assumes: APB slave on mclk; pin inputs asynchronous
// Notes: Zero-wait APB; counter width is a parameter
`timescale 1ns/1ns
`include "pwb_consts.svh"
module pwb_top #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer pins and clocks
    input wire logic timer_input_pin,
    input wire logic low_frequency_clock,
    input wire logic timer_clock_input,
    // System side
    input wire logic power_down,
    input wire logic other_timer_ovf,
    output logic timer_irq,
    output logic wakeup,
    output logic overflow,
    // Buzzer port pins
    input wire logic first_pin_in,
    output logic first_pin_out,
    output logic first_pin_oe,
    input wire logic second_pin_in,
    output logic second_pin_out,
    output logic second_pin_oe
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl2_q;
    logic [7:0] pinfn_q;
    logic [7:0] portdir_q;
    logic [7:0] portdat_q;
    logic [CNT_W-1:0] preload_q;
    logic [CNT_W-1:0] count_q;
    logic flag_q;
    logic buzz_q;
    logic ovf_q;
    logic irq_q;
    logic wake_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic p1_out_q;
    logic p1_oe_q;
    logic p2_out_q;
    logic p2_oe_q;
    pwb_pkg::pwb_state_t state_q;

    // Synchronisers: stage one feeds stage two only
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [1:0] edge_hist_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            // Timer pin idles high through its pull-up; other inputs idle low
            sync1_q <= 5'h01;
            sync2_q <= 5'h01;
        end else begin
            sync1_q <= {second_pin_in, first_pin_in, timer_clock_input,
                        low_frequency_clock, timer_input_pin};
            sync2_q <= sync1_q;
        end
    end
    logic pin_s;
    logic pin_prev_q;
    assign pin_s = sync2_q[0];
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_prev_q <= 1'b1;
            edge_hist_q <= 2'b00;
        end else begin
            pin_prev_q <= pin_s;
            edge_hist_q <= sync2_q[2:1];
        end
    end

    // Bus decode
    logic acc;
    logic wr;
    logic mapped;
    assign acc = psel & penable & pready_q;
    assign wr = acc & pwrite;
    always_comb begin
        unique case (paddr)
            `PWB_OFS_CTRL, `PWB_OFS_PRELOAD, `PWB_OFS_COUNT, `PWB_OFS_STATUS,
            `PWB_OFS_CTRL2, `PWB_OFS_PINFN, `PWB_OFS_PORTDIR, `PWB_OFS_PORTDAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Field views
    logic [1:0] mode;
    logic run;
    logic edge_sel;
    logic [2:0] psc;
    logic [1:0] csel;
    logic pw_mode;
    assign mode = ctrl_q[`PWB_CTRL_MODE_HI:`PWB_CTRL_MODE_LO];
    assign run = ctrl_q[`PWB_CTRL_RUN];
    assign edge_sel = ctrl_q[`PWB_CTRL_EDGE];
    assign psc = ctrl_q[`PWB_CTRL_PSC_HI:0];
    assign csel = ctrl2_q[`PWB_CTRL2_CSEL+1:`PWB_CTRL2_CSEL];
    assign pw_mode = (mode == `PWB_MODE_PWIDTH);

    // Transitions, not levels, drive start and stop
    logic rise;
    logic fall;
    logic start_edge;
    logic stop_edge;
    assign rise = pin_s & ~pin_prev_q;
    assign fall = ~pin_s & pin_prev_q;
    assign start_edge = edge_sel ? rise : fall;
    assign stop_edge = edge_sel ? fall : rise;

    // Counting clock: source pick, then prescaler for system-derived sources
    logic [1:0] div4_q;
    logic [6:0] pre_q;
    logic src_tick;
    logic sys_src;
    logic [6:0] pmask;
    logic tick;
    logic inhibit;
    always_ff @(posedge mclk) begin
        if (rst) begin
            div4_q <= 2'b00;
        end else begin
            div4_q <= div4_q + 2'b01;
        end
    end
    assign sys_src = (csel == `PWB_CSEL_SYS) | (csel == `PWB_CSEL_SYS4);
    always_comb begin
        unique case (csel)
            `PWB_CSEL_SYS: src_tick = 1'b1;
            `PWB_CSEL_SYS4: src_tick = (div4_q == `PWB_SYS4_DIV);
            `PWB_CSEL_LF: src_tick = edge_hist_q[0] & ~sync2_q[1];
            `PWB_CSEL_TCK: src_tick = edge_hist_q[1] & ~sync2_q[2];
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            pre_q <= 7'h00;
        end else if (src_tick) begin
            pre_q <= pre_q + 7'h01;
        end
    end
    // Prescaler runs free, so a measurement may come out one tick short
    assign pmask = 7'(({7'h00, 1'b1} << psc) - 8'h01);
    // Reads of the counter and preload writes stall counting; a tick may be lost
    assign inhibit = psel & (((paddr == `PWB_OFS_COUNT) & ~pwrite)
                             | ((paddr == `PWB_OFS_PRELOAD) & pwrite));
    assign tick = src_tick & (~sys_src | ((pre_q & pmask) == pmask)) & ~inhibit;

    // Pulse-width sequencing
    logic auto_stop;
    assign auto_stop = (state_q == pwb_pkg::PWB_COUNT) & stop_edge;
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= pwb_pkg::PWB_IDLE;
        end else begin
            unique case (state_q)
                pwb_pkg::PWB_IDLE: begin
                    if (run && pw_mode) begin
                        state_q <= pwb_pkg::PWB_ARMED;
                    end
                end
                pwb_pkg::PWB_ARMED: begin
                    if (!run || !pw_mode) begin
                        state_q <= pwb_pkg::PWB_IDLE;
                    end else if (start_edge) begin
                        state_q <= pwb_pkg::PWB_COUNT;
                    end
                end
                pwb_pkg::PWB_COUNT: begin
                    if (!run || !pw_mode || stop_edge) begin
                        state_q <= pwb_pkg::PWB_IDLE;
                    end
                end
                default: state_q <= pwb_pkg::PWB_IDLE;
            endcase
        end
    end

    // Control register; software set of run beats the automatic clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q <= `PWB_CTRL_RST;
        end else if (wr && paddr == `PWB_OFS_CTRL) begin
            ctrl_q <= pwdata[7:0] & 8'hdf;
        end else if (auto_stop && pw_mode) begin
            ctrl_q[`PWB_CTRL_RUN] <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl2_q <= 8'h00;
            pinfn_q <= 8'h00;
            portdir_q <= `PWB_PORTDIR_RST;
            portdat_q <= 8'h00;
            preload_q <= '0;
        end else if (wr) begin
            if (paddr == `PWB_OFS_CTRL2) ctrl2_q <= pwdata[7:0] & 8'h0f;
            if (paddr == `PWB_OFS_PINFN) pinfn_q <= pwdata[7:0] & 8'h03;
            if (paddr == `PWB_OFS_PORTDIR) portdir_q <= pwdata[7:0];
            if (paddr == `PWB_OFS_PORTDAT) portdat_q <= pwdata[7:0];
            if (paddr == `PWB_OFS_PRELOAD) preload_q <= pwdata[CNT_W-1:0];
        end
    end

    // Counter: ticks only count while in the counting state or timer mode running
    logic counting;
    logic ovf;
    assign counting = (state_q == pwb_pkg::PWB_COUNT)
                      | ((mode == `PWB_MODE_TIMER) & run);
    assign ovf = counting & tick & (count_q == {CNT_W{1'b1}});
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= '0;
        end else if (wr && paddr == `PWB_OFS_COUNT) begin
            count_q <= pwdata[CNT_W-1:0];
        end else if (ovf) begin
            count_q <= preload_q;
        end else if (counting && tick) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    // Request flag: an overflow in the clearing cycle still sets it
    logic flag_wr;
    assign flag_wr = wr & (paddr == `PWB_OFS_STATUS);
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ovf) begin
            flag_q <= 1'b1;
        end else if (flag_wr) begin
            flag_q <= pwdata[0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (flag_q | ovf) & ctrl2_q[`PWB_CTRL2_IEN];
        end
    end
    // Wake-up ignores the interrupt enable; a flag already high before halt masks it
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= ovf & power_down & ~flag_q;
        end
    end

    // Buzzer divide-by-two
    logic buzz_ovf;
    assign buzz_ovf = ctrl2_q[`PWB_CTRL2_BZSRC] ? other_timer_ovf : ovf;
    always_ff @(posedge mclk) begin
        if (rst) begin
            buzz_q <= 1'b0;
        end else if (buzz_ovf) begin
            buzz_q <= ~buzz_q;
        end
    end

    // Pin muxing
    logic fn1;
    logic fn2;
    logic in1;
    logic in2;
    logic d1;
    logic d2;
    assign fn1 = pinfn_q[`PWB_PINFN_FIRST];
    assign fn2 = pinfn_q[`PWB_PINFN_SECOND];
    assign in1 = portdir_q[`PWB_PIN_FIRST];
    assign in2 = portdir_q[`PWB_PIN_SECOND];
    assign d1 = portdat_q[`PWB_PIN_FIRST];
    assign d2 = portdat_q[`PWB_PIN_SECOND];
    // First pin: buzzer gated by its own data bit, or plain port output
    always_ff @(posedge mclk) begin
        if (rst) begin
            p1_out_q <= 1'b0;
            p1_oe_q <= 1'b0;
        end else begin
            p1_oe_q <= ~in1;
            p1_out_q <= fn1 ? (d1 & buzz_q) : d1;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            p2_out_q <= 1'b0;
            p2_oe_q <= 1'b0;
        end else begin
            p2_oe_q <= ~in2;
            if (fn2) begin
                // Second pin gated by first pin's data only
                p2_out_q <= d1 & (in1 ? buzz_q : ~buzz_q);
            end else begin
                p2_out_q <= d2;
            end
        end
    end

    // APB: zero-wait, answer prepared in setup phase
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        unique case (paddr)
            `PWB_OFS_CTRL: rd[7:0] = ctrl_q;
            `PWB_OFS_PRELOAD: rd[CNT_W-1:0] = preload_q;
            `PWB_OFS_COUNT: rd[CNT_W-1:0] = count_q;
            `PWB_OFS_STATUS: rd[3:0] = {sync2_q[4:3], state_q == pwb_pkg::PWB_COUNT, flag_q};
            `PWB_OFS_CTRL2: rd[7:0] = ctrl2_q;
            `PWB_OFS_PINFN: rd[7:0] = pinfn_q;
            `PWB_OFS_PORTDIR: rd[7:0] = portdir_q;
            `PWB_OFS_PORTDAT: rd[7:0] = portdat_q;
            default: rd = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= psel & ~penable;
        end
    end
    // Unmapped offsets answer with an error; writes there change nothing
    always_ff @(posedge mclk) begin
        if (rst) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= psel & ~penable & ~mapped;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign timer_irq = irq_q;
    assign wakeup = wake_q;
    assign overflow = ovf_q;
    assign first_pin_out = p1_out_q;
    assign first_pin_oe = p1_oe_q;
    assign second_pin_out = p2_out_q;
    assign second_pin_oe = p2_oe_q;
endmodule

/* File: dv/pwb_props.sv */
// Purpose: Port-level checks for pwb_top
// Assumes: Pin config is shadowed from APB writes
// Notes: Pin outputs lag config by one cycle
`timescale 1ns/1ns
`include "pwb_consts.svh"
module pwb_props #(
    parameter int CNT_W = 8
) (
    // Clock, reset, APB
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Events and pins
    input wire logic power_down,
    input wire logic other_timer_ovf,
    input wire logic timer_irq,
    input wire logic wakeup,
    input wire logic overflow,
    input wire logic first_pin_out,
    input wire logic first_pin_oe,
    input wire logic second_pin_out,
    input wire logic second_pin_oe
);
    logic wr;
    logic hold_q;
    logic pair;
    logic solo;
    logic [1:0] fn_q, dir_q, dat_q, c2_q;
    assign wr = psel && penable && pready && pwrite;
    // Config must be settled a cycle before pins are judged
    assign pair = hold_q && fn_q == 2'h3 && dir_q == 2'h0;
    assign solo = hold_q && fn_q[0] && !dir_q[0] && dat_q[0];
    always_ff @(posedge mclk) begin
        hold_q <= !wr && !rst;
        if (rst) begin
            fn_q <= 2'h0;
            dir_q <= 2'h3;
            dat_q <= 2'h0;
            c2_q <= 2'h0;
        end else if (wr) begin
            if (paddr == `PWB_OFS_PINFN) fn_q <= pwdata[1:0];
            if (paddr == `PWB_OFS_PORTDIR) dir_q <= pwdata[2:1];
            if (paddr == `PWB_OFS_PORTDAT) dat_q <= pwdata[2:1];
            if (paddr == `PWB_OFS_CTRL2) c2_q <= pwdata[1:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_pair_inverse: assert property (
        pair && dat_q[0] |-> second_pin_out != first_pin_out) else $error("pair not inverse");
    a_pair_gate_low: assert property (
        pair && !dat_q[0] |-> first_pin_oe && second_pin_oe && !first_pin_out && !second_pin_out)
        else $error("pair not forced low");
    a_dir_input: assert property (
        hold_q && fn_q[0] && dir_q[0] |-> !first_pin_oe) else $error("input pin driven");
    a_io_mode: assert property (
        hold_q && !fn_q[0] && !dir_q[0] |-> first_pin_oe && first_pin_out == dat_q[0])
        else $error("plain port output wrong");
    a_buz_toggle: assert property (
        solo && c2_q[1] && other_timer_ovf |-> ##[1:3] $changed(first_pin_out))
        else $error("buzzer did not toggle");
    a_irq_gate: assert property (
        timer_irq |-> c2_q[0] || $past(c2_q[0])) else $error("irq without enable");
    a_ovf_irq: assert property (
        overflow && c2_q[0] |=> timer_irq) else $error("overflow gave no irq");
    a_wake_cause: assert property (
        wakeup |-> (overflow || $past(overflow)) && (power_down || $past(power_down)))
        else $error("stray wakeup");
    cover property (wakeup);
    cover property (overflow && c2_q[0]);
    cover property (pair && dat_q[0] && $changed(first_pin_out));
endmodule
bind pwb_top pwb_props #(.CNT_W(CNT_W)) pwb_props_i (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .power_down(power_down), .other_timer_ovf(other_timer_ovf), .timer_irq(timer_irq),
    .wakeup(wakeup), .overflow(overflow), .first_pin_out(first_pin_out),
    .first_pin_oe(first_pin_oe), .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe));

/* File: dv/pwb_pin_src.sv */
// Purpose: Pulse source on the timer pin and buzzer load on the port pins
// Assumes: Called just after a rising mclk edge
// Notes: Port pins have pull-downs, so a released pin reads low
`timescale 1ns/1ns
module pwb_pin_src (
    input wire logic mclk,
    output logic timer_pin,
    input wire logic first_pin_out,
    input wire logic first_pin_oe,
    input wire logic second_pin_out,
    input wire logic second_pin_oe,
    output logic first_pin,
    output logic second_pin
);
    initial timer_pin = 1'h1;
    assign first_pin = first_pin_oe ? first_pin_out : 1'h0;
    assign second_pin = second_pin_oe ? second_pin_out : 1'h0;
    task automatic idle(input logic lvl);
        timer_pin <= lvl;
    endtask
    task automatic pulse(input logic act, input int w);
        timer_pin <= act;
        repeat (w) @(posedge mclk);
        timer_pin <= !act;
    endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for pwb_top
// Assumes: Zero-wait APB slave
// Notes: Expected reads are queued and compared on completion
`timescale 1ns/1ns
`include "pwb_consts.svh"
module testbench;
    typedef struct {logic [31:0] e; logic [31:0] m; logic [31:0] t;} pwb_exp_t;
    logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic lfc = 1'h0, tck = 1'h0, pd = 1'h0, oovf = 1'h0, b = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h8a5b, ex;
    logic pready, pslverr, tpin, irq, wake, ovf, fo, foe, so, soe, fpin, spin;
    pwb_exp_t q[$];
    int err_total = 0, num_checks = 0, wake_n = 0, w;
    always #25 mclk = ~mclk;
    always #200 lfc = ~lfc;
    always #150 tck = ~tck;
    pwb_top #(.CNT_W(8)) pwb_top_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input_pin(tpin), .low_frequency_clock(lfc),
        .timer_clock_input(tck), .power_down(pd), .other_timer_ovf(oovf), .timer_irq(irq),
        .wakeup(wake), .overflow(ovf), .first_pin_in(fpin), .first_pin_out(fo),
        .first_pin_oe(foe), .second_pin_in(spin), .second_pin_out(so), .second_pin_oe(soe));
    pwb_pin_src pwb_pin_src_i (.mclk(mclk), .timer_pin(tpin), .first_pin_out(fo),
        .first_pin_oe(foe), .second_pin_out(so), .second_pin_oe(soe), .first_pin(fpin),
        .second_pin(spin));
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s, t);
        num_checks++;
        if ((^s) === 1'hx || s + t < e || s > e + t) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= wt;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            err_total++;
            give_verdict();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, t = 32'h0, m = 32'hffffffff);
        q.push_back('{e, m, t});
        apb(1'h0, a, 32'h0);
    endtask
    task automatic wait_ovf;
        int n;
        n = 0;
        while (ovf !== 1'h1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        if (ovf !== 1'h1) begin
            err_total++;
            give_verdict();
        end
        repeat (2) @(posedge mclk);
    endtask
    task automatic bz_pulse;
        oovf <= 1'h1;
        @(posedge mclk);
        oovf <= 1'h0;
        b = !b;
        repeat (8) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        pwb_exp_t x;
        if (wake === 1'h1) wake_n++;
        if (psel && penable && pready === 1'h1)
            chk("slverr", {31'h0, paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0}, pslverr, 0);
        if (psel && penable && pready === 1'h1 && !pwrite && q.size() > 0) begin
            x = q.pop_front();
            chk("read data", x.e, prdata & x.m, x.t);
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        rd(`PWB_OFS_CTRL, 32'h08);
        rd(`PWB_OFS_PINFN, 32'h0);
        rd(8'h20, 32'h0);
        wr(`PWB_OFS_CTRL2, 32'h2);
        wr(`PWB_OFS_PORTDAT, 32'h2);
        wr(`PWB_OFS_PORTDIR, 32'hf9);
        wr(`PWB_OFS_PINFN, 32'h3);
        for (int i = 0; i < 3; i++) begin
            bz_pulse();
            rd(`PWB_OFS_STATUS, {28'h0, !b, b, 2'h0}, 0, 32'hc);
        end
        wr(`PWB_OFS_PORTDAT, 32'h4);
        repeat (4) @(posedge mclk);
        rd(`PWB_OFS_STATUS, 32'h0, 0, 32'hc);
        wr(`PWB_OFS_PORTDIR, 32'hfb);
        wr(`PWB_OFS_PORTDAT, 32'h6);
        repeat (4) @(posedge mclk);
        rd(`PWB_OFS_STATUS, {28'h0, b, 3'h0}, 0, 32'hc);
        wr(`PWB_OFS_PINFN, 32'h0);
        wr(`PWB_OFS_PORTDIR, 32'hf9);
        wr(`PWB_OFS_PORTDAT, 32'h2);
        repeat (4) @(posedge mclk);
        rd(`PWB_OFS_STATUS, 32'h4, 0, 32'hc);
        for (int k = 0; k < 8; k++) begin
            lfsr = nxt(lfsr);
            w = 40 + int'(lfsr[5:0]);
            ex = w / (k < 2 ? 1 : k < 4 ? 4 : k < 6 ? 8 : 6);
            pwb_pin_src_i.idle(!k[0]);
            wr(`PWB_OFS_CTRL2, {28'h0, k[2:1], 2'h0});
            wr(`PWB_OFS_PRELOAD, lfsr);
            wr(`PWB_OFS_COUNT, 32'h0);
            wr(`PWB_OFS_CTRL, {24'h0, 4'hd, k[0], 3'h0});
            repeat (10) @(posedge mclk);
            rd(`PWB_OFS_COUNT, 32'h0);
            pwb_pin_src_i.pulse(k[0], w);
            repeat (8) @(posedge mclk);
            rd(`PWB_OFS_CTRL, {24'h0, 4'hc, k[0], 3'h0});
            rd(`PWB_OFS_COUNT, ex, 3);
            pwb_pin_src_i.pulse(k[0], 20);
            repeat (8) @(posedge mclk);
            rd(`PWB_OFS_COUNT, ex, 3);
        end
        wr(`PWB_OFS_CTRL2, 32'h0);
        wr(`PWB_OFS_STATUS, 32'h0);
        wr(`PWB_OFS_PRELOAD, 32'hf0);
        wr(`PWB_OFS_COUNT, 32'hfe);
        pd <= 1'h1;
        wr(`PWB_OFS_CTRL, 32'h90);
        wait_ovf();
        pd <= 1'h0;
        chk("wakeups", 1, wake_n, 0);
        rd(`PWB_OFS_STATUS, 32'h1, 0, 32'h1);
        rd(`PWB_OFS_CTRL, 32'h90);
        wr(`PWB_OFS_STATUS, 32'h1);
        pd <= 1'h1;
        wait_ovf();
        pd <= 1'h0;
        chk("wakeups", 1, wake_n, 0);
        chk("irq", 0, irq, 0);
        wr(`PWB_OFS_CTRL2, 32'h1);
        wait_ovf();
        chk("irq", 1, irq, 0);
        wr(`PWB_OFS_CTRL, 32'h08);
        rd(`PWB_OFS_COUNT, 32'hf5, 1);
        give_verdict();
    end
endmodule
